// ==== design/intf_desc_pkg.sv ====
/*
  Constants for the interface descriptor ROM: byte offsets, fixed field
  values, class codes and the descriptor type codes used in sequencing.
  Assumes nothing of its surroundings; imported by the ROM module.
*/
package intf_desc_pkg;

  // =========================================================
  // Byte offsets of the nine-byte interface descriptor
  localparam logic [3:0] OFS_LENGTH    = 4'h0;
  localparam logic [3:0] OFS_TYPE      = 4'h1;
  localparam logic [3:0] OFS_IFC_NUM   = 4'h2;
  localparam logic [3:0] OFS_ALT_SET   = 4'h3;
  localparam logic [3:0] OFS_NUM_EP    = 4'h4;
  localparam logic [3:0] OFS_CLASS     = 4'h5;
  localparam logic [3:0] OFS_SUBCLASS  = 4'h6;
  localparam logic [3:0] OFS_PROTOCOL  = 4'h7;
  localparam logic [3:0] OFS_STR_IDX   = 4'h8;
  localparam logic [3:0] LAST_OFS      = 4'h8;

  // =========================================================
  // Fixed field values and codes
  localparam logic [7:0] DESC_LEN      = 8'h09;
  localparam logic [7:0] TYPE_IFC      = 8'h04;
  localparam logic [7:0] TYPE_CONFIG   = 8'h02;
  localparam logic [7:0] CODE_RESERVED = 8'h00;
  localparam logic [7:0] CODE_VENDOR   = 8'hFF;
  localparam logic [7:0] ALT_DEFAULT   = 8'h00;

  // Reset values of the output registers
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] RST_OFS       = 4'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b10
  } seq_state_t;

endpackage

// ==== design/intf_desc_rom.sv ====
/*
  Interface descriptor source. On a request that names a configuration
  fetch, streams the nine descriptor bytes in order, one per cycle, then
  raises a done pulse so the endpoint descriptors can follow directly.
  A direct request for this descriptor on its own is answered by a one
  cycle refusal pulse and no bytes. A handful of registered flags tell the
  host-facing logic whether the class and protocol codes are reserved or
  vendor-specific, and whether the default alternate setting is selected.
  Assumes a request decoder upstream, field values held stable by the
  configuration logic, and a consumer that accepts one byte per cycle.
  A start that arrives while a stream or its done cycle is under way is
  dropped, not queued; the requester must wait for the done pulse.
  Everything runs in the one core clock domain with a synchronous reset.
*/
`timescale 1ns/1ps

module intf_desc_rom (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     start,
  input  wire logic [7:0]               req_type,
  input  wire logic [7:0]               ifc_num,
  input  wire logic [7:0]               alt_set,
  input  wire logic [7:0]               num_ep,
  input  wire logic [7:0]               ifc_class,
  input  wire logic [7:0]               ifc_subclass,
  input  wire logic [7:0]               ifc_protocol,
  input  wire logic [7:0]               str_idx,
  output logic      [7:0]               byte_out_ff,
  output logic      [3:0]               byte_ofs_ff,
  output logic                          byte_valid_ff,
  output logic                          desc_done_ff,
  output logic                          req_reject_ff,
  output logic                          is_default_ff,
  output logic                          class_vendor_ff,
  output logic                          class_reserved_ff,
  output logic                          proto_none_ff,
  output logic                          proto_vendor_ff
);
  import intf_desc_pkg::*;

  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [3:0] ofs_ff;
  logic [7:0] nxt_byte;

  // =========================================================
  // Field selection by offset
  function automatic logic [7:0] field_at(input logic [3:0] ofs);
    logic [7:0] v;
    v = RST_BYTE;
    case (ofs)
      OFS_LENGTH:   v = DESC_LEN;
      OFS_TYPE:     v = TYPE_IFC;
      OFS_IFC_NUM:  v = ifc_num;
      OFS_ALT_SET:  v = alt_set;
      OFS_NUM_EP:   v = num_ep;
      OFS_CLASS:    v = ifc_class;
      // Reserved class leaves no room for a subclass meaning
      OFS_SUBCLASS: v = (ifc_class == CODE_RESERVED) ? CODE_RESERVED
                                                     : ifc_subclass;
      OFS_PROTOCOL: v = ifc_protocol;
      OFS_STR_IDX:  v = str_idx;
      default:      v = RST_BYTE;
    endcase
    return v;
  endfunction

  // Process rather than a continuous assignment: the function reads the
  // field inputs directly, and a process also wakes when those change
  always_comb begin
    nxt_byte = field_at(ofs_ff);
  end

  // =========================================================
  // Byte-wide code match, shared by the sequencer, the request filter and
  // the classification flags so their code comparisons read the same way
  function automatic logic code_is(input logic [7:0] value,
                                   input logic [7:0] code);
    return (value == code);
  endfunction

  // =========================================================
  // Sequencer: only a configuration fetch starts a stream
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start && code_is(req_type, TYPE_CONFIG)) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (ofs_ff == LAST_OFS) begin
          nxt_state = ST_DONE;
        end
      end
      // One spare cycle: a start here is dropped, so the done pulse never
      // overlaps the first byte of a following stream
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Offset counter walks 0..8 while sending
  always_ff @(posedge clk) begin
    if (reset) begin
      ofs_ff <= RST_OFS;
    end else if (state_ff == ST_SEND) begin
      ofs_ff <= (ofs_ff == LAST_OFS) ? RST_OFS : ofs_ff + 4'h1;
    end else begin
      ofs_ff <= RST_OFS;
    end
  end

  // =========================================================
  // Byte stream outputs, registered one cycle behind the offset
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_out_ff   <= RST_BYTE;
      byte_ofs_ff   <= RST_OFS;
      byte_valid_ff <= 1'b0;
    end else if (state_ff == ST_SEND) begin
      byte_out_ff   <= nxt_byte;
      byte_ofs_ff   <= ofs_ff;
      byte_valid_ff <= 1'b1;
    end else begin
      byte_out_ff   <= RST_BYTE;
      byte_ofs_ff   <= RST_OFS;
      byte_valid_ff <= 1'b0;
    end
  end

  // Done pulse on the cycle after the last byte: endpoint list may follow
  always_ff @(posedge clk) begin
    if (reset) begin
      desc_done_ff <= 1'b0;
    end else begin
      desc_done_ff <= (state_ff == ST_DONE);
    end
  end

  // Direct request for this descriptor alone is refused, not served
  always_ff @(posedge clk) begin
    if (reset) begin
      req_reject_ff <= 1'b0;
    end else begin
      req_reject_ff <= start && state_ff == ST_IDLE
                       && code_is(req_type, TYPE_IFC);
    end
  end

  // =========================================================
  // Field classification flags, level outputs for the host-facing logic.
  // Registered, so they trail a field change by one cycle; the host side
  // must not read them in the cycle in which it rewrites a field.

  // Alternate setting zero is the default one
  always_ff @(posedge clk) begin
    if (reset) begin
      is_default_ff <= 1'b0;
    end else begin
      is_default_ff <= code_is(alt_set, ALT_DEFAULT);
    end
  end

  // Vendor class: the subclass then carries a vendor meaning
  always_ff @(posedge clk) begin
    if (reset) begin
      class_vendor_ff <= 1'b0;
    end else begin
      class_vendor_ff <= code_is(ifc_class, CODE_VENDOR);
    end
  end

  // Class zero is held back for future use
  always_ff @(posedge clk) begin
    if (reset) begin
      class_reserved_ff <= 1'b0;
    end else begin
      class_reserved_ff <= code_is(ifc_class, CODE_RESERVED);
    end
  end

  // Protocol zero: no class-specific protocol on this interface
  always_ff @(posedge clk) begin
    if (reset) begin
      proto_none_ff <= 1'b0;
    end else begin
      proto_none_ff <= code_is(ifc_protocol, CODE_RESERVED);
    end
  end

  // Vendor protocol code
  always_ff @(posedge clk) begin
    if (reset) begin
      proto_vendor_ff <= 1'b0;
    end else begin
      proto_vendor_ff <= code_is(ifc_protocol, CODE_VENDOR);
    end
  end

endmodule

// ==== dv/host_reader.sv ====
/*
  Host-side consumer of descriptor bytes.
  Assumes one byte per cycle while valid, then a done pulse.
*/
`timescale 1ns/1ps
module host_reader (
  input  wire logic        clk,
  input  wire logic [7:0]  byte_out_ff,
  input  wire logic [3:0]  byte_ofs_ff,
  input  wire logic        byte_valid_ff,
  input  wire logic        desc_done_ff,
  output logic      [71:0] got,
  output logic      [35:0] ofs_log,
  output logic      [3:0]  n_bytes
);
  logic [3:0] cnt_ff = 4'h0;
  // Store bytes and offsets in arrival order; the bench judges order
  always @(posedge clk) begin
    if (byte_valid_ff) begin
      got[cnt_ff * 8 +: 8] <= byte_out_ff;
      ofs_log[cnt_ff * 4 +: 4] <= byte_ofs_ff;
      cnt_ff <= cnt_ff + 4'h1;
    end
    if (desc_done_ff) begin
      n_bytes <= cnt_ff;
      cnt_ff <= 4'h0;
    end
  end
endmodule

// ==== dv/intf_desc_rom_assertions.sv ====
/*
  Checker for the descriptor ROM ports.
  Assumes field inputs stay stable during a stream.
*/
`timescale 1ns/1ps
module intf_desc_rom_assertions (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] alt_set,
  input wire logic [7:0] ifc_class,
  input wire logic [7:0] ifc_protocol,
  input wire logic [7:0] byte_out_ff,
  input wire logic [3:0] byte_ofs_ff,
  input wire logic       byte_valid_ff,
  input wire logic       desc_done_ff,
  input wire logic       req_reject_ff,
  input wire logic       is_default_ff,
  input wire logic       class_vendor_ff,
  input wire logic       class_reserved_ff,
  input wire logic       proto_none_ff,
  input wire logic       proto_vendor_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic v;
  assign v = byte_valid_ff;
  // ========================================
  // Byte stream
  chk_len_byte: assert property (
    v && byte_ofs_ff == 4'h0 |-> byte_out_ff == 8'h09)
    else $error("length byte wrong");
  chk_type_byte: assert property (
    v && byte_ofs_ff == 4'h1 |-> byte_out_ff == 8'h04)
    else $error("type byte wrong");
  chk_ofs_step: assert property (
    v && byte_ofs_ff < 4'h8 |=> v && byte_ofs_ff == $past(byte_ofs_ff) + 4'h1)
    else $error("offset not stepping");
  chk_alt_byte: assert property (
    v && byte_ofs_ff == 4'h3 |-> byte_out_ff == alt_set)
    else $error("alternate byte wrong");
  chk_sub_zero: assert property (
    v && byte_ofs_ff == 4'h6 && ifc_class == 8'h00 |-> byte_out_ff == 8'h00)
    else $error("subclass not zeroed");
  chk_done_pulse: assert property (
    v && byte_ofs_ff == 4'h8 |=> !v && desc_done_ff ##1 !desc_done_ff)
    else $error("done pulse wrong");
  chk_reject_quiet: assert property (
    req_reject_ff |-> (!v) [*3])
    else $error("bytes after refusal");
  // ========================================
  // Flags, from inputs one edge earlier
  chk_default_flag: assert property (
    !$past(reset) && !$past(reset, 2)
    |-> is_default_ff == ($past(alt_set) == 8'h00))
    else $error("default flag wrong");
  chk_vendor_flag: assert property (
    !$past(reset) && !$past(reset, 2)
    |-> class_vendor_ff == ($past(ifc_class) == 8'hFF)
        && proto_vendor_ff == ($past(ifc_protocol) == 8'hFF))
    else $error("vendor flag wrong");
  chk_reserved_flag: assert property (
    !$past(reset) && !$past(reset, 2)
    |-> class_reserved_ff == ($past(ifc_class) == 8'h00)
        && proto_none_ff == ($past(ifc_protocol) == 8'h00))
    else $error("reserved flag wrong");
endmodule
bind intf_desc_rom intf_desc_rom_assertions i_chk (
  .clk               (clk),
  .reset             (reset),
  .alt_set           (alt_set),
  .ifc_class         (ifc_class),
  .ifc_protocol      (ifc_protocol),
  .byte_out_ff       (byte_out_ff),
  .byte_ofs_ff       (byte_ofs_ff),
  .byte_valid_ff     (byte_valid_ff),
  .desc_done_ff      (desc_done_ff),
  .req_reject_ff     (req_reject_ff),
  .is_default_ff     (is_default_ff),
  .class_vendor_ff   (class_vendor_ff),
  .class_reserved_ff (class_reserved_ff),
  .proto_none_ff     (proto_none_ff),
  .proto_vendor_ff   (proto_vendor_ff)
);

// ==== dv/intf_desc_rom_test.sv ====
/*
  Self-checking bench for the descriptor ROM.
  Assumes the host_reader model and the bound checker.
*/
`timescale 1ns/1ps
module intf_desc_rom_test;
  logic        clk;
  logic        reset;
  logic        start;
  logic        bv;
  logic        dd;
  logic        rj;
  logic        df;
  logic        cv;
  logic        cr;
  logic        pn;
  logic        pv;
  logic [7:0]  req_type;
  logic [7:0]  ifc_num;
  logic [7:0]  alt_set;
  logic [7:0]  num_ep;
  logic [7:0]  ifc_class;
  logic [7:0]  ifc_subclass;
  logic [7:0]  ifc_protocol;
  logic [7:0]  str_idx;
  logic [7:0]  bo;
  logic [71:0] got;
  logic [35:0] ofs_log;
  logic [3:0]  n_bytes;
  logic [3:0]  bofs;
  int          miscompares;
  int          cmp_count;
  intf_desc_rom i_intf_desc_rom (
    .clk               (clk),
    .reset             (reset),
    .start             (start),
    .req_type          (req_type),
    .ifc_num           (ifc_num),
    .alt_set           (alt_set),
    .num_ep            (num_ep),
    .ifc_class         (ifc_class),
    .ifc_subclass      (ifc_subclass),
    .ifc_protocol      (ifc_protocol),
    .str_idx           (str_idx),
    .byte_out_ff       (bo),
    .byte_ofs_ff       (bofs),
    .byte_valid_ff     (bv),
    .desc_done_ff      (dd),
    .req_reject_ff     (rj),
    .is_default_ff     (df),
    .class_vendor_ff   (cv),
    .class_reserved_ff (cr),
    .proto_none_ff     (pn),
    .proto_vendor_ff   (pv)
  );
  host_reader i_host_reader (
    .clk           (clk),
    .byte_out_ff   (bo),
    .byte_ofs_ff   (bofs),
    .byte_valid_ff (bv),
    .desc_done_ff  (dd),
    .got           (got),
    .ofs_log       (ofs_log),
    .n_bytes       (n_bytes)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] t);
    @(negedge clk);
    start = 1'b1;
    req_type = t;
    @(negedge clk);
    start = 1'b0;
  endtask
  // Second start lands mid-stream and must be ignored
  task automatic stream(input logic [7:0] c,
                        input logic [7:0] s,
                        input logic [7:0] p,
                        input logic [7:0] a);
    logic [7:0] e [9];
    ifc_class = c;
    ifc_subclass = s;
    ifc_protocol = p;
    alt_set = a;
    e = '{8'h09, 8'h04, ifc_num, a, num_ep, c, (c == 8'h00) ? 8'h00 : s, p, str_idx};
    send(8'h02);
    send(8'h02);
    repeat (20) @(negedge clk) if (dd === 1'b1) break;
    @(negedge clk);
    chk({4'h0, n_bytes}, 8'h09);
    for (int i = 0; i < 9; i++) begin
      chk(got[i * 8 +: 8], e[i]);
      chk({4'h0, ofs_log[i * 4 +: 4]}, 8'(i));
    end
    chk({6'h0, df, cv}, {6'h0, a == 8'h00, c == 8'hFF});
    chk({5'h0, cr, pn, pv}, {5'h0, c == 8'h00, p == 8'h00, p == 8'hFF});
    $display("stream test done");
  endtask
  // Direct fetch refused, unknown type silent
  task automatic refuse(input logic [7:0] t);
    logic seen;
    send(t);
    chk({7'h0, rj}, {7'h0, t == 8'h04});
    seen = 1'b0;
    repeat (12) @(negedge clk) seen |= bv;
    chk({7'h0, seen}, 8'h00);
    $display("refuse test done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  initial begin
    reset = 1'b1;
    start = 1'b0;
    req_type = 8'h00;
    alt_set = 8'h00;
    ifc_class = 8'h00;
    ifc_subclass = 8'h00;
    ifc_protocol = 8'h00;
    ifc_num = 8'h01;
    num_ep = 8'h02;
    str_idx = 8'h05;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    stream(8'h03, 8'h01, 8'h02, 8'h01);
    num_ep = 8'h00;
    stream(8'h00, 8'h5A, 8'h00, 8'h00);
    ifc_num = 8'h00;
    stream(8'hFF, 8'h22, 8'hFF, 8'h02);
    refuse(8'h04);
    refuse(8'h01);
    complete_run;
  end
endmodule
